// ==== verilog/ats_pkg.sv ====
// Shared constants for the analyzer tap and probe extension block
package ats_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 16;
    localparam int PROBE_W    = 8;
    localparam int PORT_W     = 32;
    localparam int QUAL_W     = 7;
    localparam int CNT_W      = 4;
    // ------------------------------------------------------------
    // Qualifier line positions
    // ------------------------------------------------------------
    localparam int Q_IRQ_ACK  = 0;
    localparam int Q_PROG_SP  = 1;
    localparam int Q_RW_READ  = 2;
    localparam int Q_IFETCH   = 3;
    localparam int Q_PA_VALID = 4;
    localparam int Q_DATA_SP  = 5;
    localparam int Q_BRANCH   = 6;
    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_EXT  = 8'h08;
    localparam int CTRL_CNT_LSB     = 0;
    localparam int CTRL_ALT_BIT     = 4;
    localparam int STAT_RUN_BIT     = 0;
    localparam int STAT_EXEC_BIT    = 1;
    localparam int STAT_DROP_LSB    = 8;
    localparam int EXT_DATA_LSB     = 8;
    localparam logic [CNT_W-1:0] EXT_CNT_RST = 4'h0;  // All probes are data
    localparam logic [CNT_W-1:0] EXT_CNT_MAX = 4'h8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Link-side sequencing state
    typedef enum logic [0:0] {LK_IDLE, LK_FALL} ats_link_st_t;
endpackage : ats_pkg

// ==== verilog/ats_sync2.sv ====
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ns
`default_nettype none
module ats_sync2 #(
    parameter int W = 1
) (
    // Destination clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Level in and synchronised level out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            d_out  <= '0;
        end else begin
            meta_r <= d_in;
            d_out  <= meta_r;
        end
    end
endmodule : ats_sync2
`default_nettype wire

// ==== verilog/ats_probe_split.sv ====
// Splits the eight probe bits into extended address and extended data
`timescale 1ns/1ns
`default_nettype none
module ats_probe_split
    import ats_pkg::*;
(
    // Number of probe bits taken as address
    input  wire logic [CNT_W-1:0]   addr_cnt,
    // Synchronised probe levels
    input  wire logic [PROBE_W-1:0] probe,
    // Split result
    output logic      [PROBE_W-1:0] ext_addr,
    output logic      [PROBE_W-1:0] ext_data
);
    logic [PROBE_W:0] mask;

    // Low bits go to address, the rest shift down into the data byte
    always_comb begin
        mask     = ({{PROBE_W{1'b0}}, 1'b1} << addr_cnt) - 9'h001;
        ext_addr = probe & mask[PROBE_W-1:0];
        ext_data = probe >> addr_cnt;
    end
endmodule : ats_probe_split
`default_nettype wire

// ==== verilog/ats_tap.sv ====
// Analyzer tap: bus cycle capture, probe extension, analyzer port, AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ats_tap
    import ats_pkg::*;
(
    // Emulation clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Analyzer link clock
    input  wire logic                clk_link,
    // Bus cycle from the emulation logic
    input  wire logic                bus_cycle_stb,
    input  wire logic [ADDR_W-1:0]   bus_addr,
    input  wire logic [DATA_W-1:0]   bus_data,
    input  wire logic                irq_accept_qual,
    input  wire logic                prog_space_strobe_qual,
    input  wire logic                data_space_strobe_qual,
    input  wire logic                rw_read,
    input  wire logic                instr_fetch_qual,
    input  wire logic                prog_addr_valid_qual,
    // Evaluation results for that cycle
    input  wire logic                bp_cond,
    input  wire logic                trace_capture,
    input  wire logic                events_done,
    input  wire logic                event_count_zero,
    // Emulator state
    input  wire logic                cmd_entry,
    input  wire logic                target_exec,
    // Pins
    input  wire logic [PROBE_W-1:0]  probe_in,
    input  wire logic                branch_in,
    // Analyzer port (link domain); no sequencer state lines here
    output logic      [PORT_W-1:0]   la_addr,
    output logic      [PORT_W-1:0]   la_data,
    output logic      [QUAL_W-1:0]   qualifier_lines,
    output logic                     sample_clk,
    output logic                     run_flag,
    output logic                     bp_event_flag,
    output logic                     trace_sample_flag,
    output logic                     halt_pending_flag,
    // AXI4-Lite slave
    input  wire logic [7:0]          s_awaddr,
    input  wire logic                s_awvalid,
    output logic                     s_awready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    input  wire logic                s_wvalid,
    output logic                     s_wready,
    output logic [1:0]               s_bresp,
    output logic                     s_bvalid,
    input  wire logic                s_bready,
    input  wire logic [7:0]          s_araddr,
    input  wire logic                s_arvalid,
    output logic                     s_arready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    output logic                     s_rvalid,
    input  wire logic                s_rready
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int PKT_W = ADDR_W + DATA_W + 2 * PROBE_W + 6 + 3;
    logic [PROBE_W-1:0] probe_s;
    logic [PROBE_W-1:0] split_addr;
    logic [PROBE_W-1:0] split_data;
    logic [CNT_W-1:0]   ext_cnt_r;
    logic               alt_run_r;
    logic               run_sys_r;
    logic               exec_sys_r;
    logic [7:0]         drop_cnt_r;
    logic               req_tgl_r;
    logic               ack_s;
    logic               busy;
    logic               take;
    logic [PKT_W-1:0]   hold_r;
    logic               hold_evt_r;
    logic               hold_trc_r;
    logic               hold_zro_r;
    logic [PROBE_W-1:0] hold_ext_addr_r;
    logic [PROBE_W-1:0] hold_ext_data_r;
    // Link side
    logic               req_s;
    logic               req_seen_r;
    logic               ack_tgl_r;
    logic               run_s;
    logic               branch_s;
    ats_link_st_t       lk_st_r;
    logic [2:0]         prev_eval_r;
    logic               load;
    // Bus slave
    logic               aw_got_r;
    logic               w_got_r;
    logic [7:0]         aw_addr_r;
    logic [31:0]        w_data_r;
    logic [3:0]         w_strb_r;
    // ------------------------------------------------------------
    // Probe synchronisation and split
    // ------------------------------------------------------------
    ats_sync2 #(.W(PROBE_W)) u_probe_sync (
        .clk   (clk_sys),
        .rst   (rst),
        .d_in  (probe_in),
        .d_out (probe_s)
    );
    ats_probe_split u_split (
        .addr_cnt (ext_cnt_r),
        .probe    (probe_s),
        .ext_addr (split_addr),
        .ext_data (split_data)
    );
    // ------------------------------------------------------------
    // Bus cycle capture and crossing request
    // ------------------------------------------------------------
    // A new cycle is held until the link side acknowledges it
    assign busy = req_tgl_r != ack_s;
    assign take = bus_cycle_stb && !busy;
    ats_sync2 #(.W(1)) u_ack_sync (
        .clk   (clk_sys),
        .rst   (rst),
        .d_in  (ack_tgl_r),
        .d_out (ack_s)
    );
    // Probes ride along with the same cycle as address and data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_r          <= '0;
            hold_evt_r      <= 1'b1;
            hold_trc_r      <= 1'b0;
            hold_zro_r      <= 1'b1;
            hold_ext_addr_r <= '0;
            hold_ext_data_r <= '0;
            req_tgl_r       <= 1'b0;
        end else if (take) begin
            hold_r          <= {bus_addr, bus_data, irq_accept_qual, prog_space_strobe_qual,
                                rw_read, instr_fetch_qual, prog_addr_valid_qual,
                                data_space_strobe_qual, split_addr, split_data, 3'h0};
            hold_evt_r      <= ~bp_cond;
            hold_trc_r      <= trace_capture;
            hold_zro_r      <= ~(events_done & event_count_zero);
            hold_ext_addr_r <= split_addr;
            hold_ext_data_r <= split_data;
            req_tgl_r       <= ~req_tgl_r;
        end
    end
    // Cycles arriving while a transfer is in flight are counted, not queued
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drop_cnt_r <= 8'h00;
        end else if (bus_cycle_stb && busy && drop_cnt_r != 8'hFF) begin
            drop_cnt_r <= drop_cnt_r + 8'h01;
        end
    end
    // Emulator state; alt-run keeps exec visible apart from the flag
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_sys_r  <= 1'b1;
            exec_sys_r <= 1'b0;
        end else begin
            run_sys_r  <= cmd_entry;
            exec_sys_r <= target_exec && (!cmd_entry || alt_run_r);
        end
    end
    // ------------------------------------------------------------
    // Link domain: analyzer port
    // ------------------------------------------------------------
    ats_sync2 #(.W(3)) u_link_sync (
        .clk   (clk_link),
        .rst   (rst),
        .d_in  ({req_tgl_r, run_sys_r, branch_in}),
        .d_out ({req_s, run_s, branch_s})
    );
    assign load = (lk_st_r == LK_IDLE) && (req_s != req_seen_r);
    // Load raises the sample clock; next edge lowers it with data stable
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            lk_st_r    <= LK_IDLE;
            req_seen_r <= 1'b0;
            ack_tgl_r  <= 1'b0;
            sample_clk <= 1'b0;
        end else begin
            unique case (lk_st_r)
                LK_IDLE: begin
                    if (load) begin
                        req_seen_r <= req_s;
                        sample_clk <= 1'b1;
                        lk_st_r    <= LK_FALL;
                    end
                end
                LK_FALL: begin
                    sample_clk <= 1'b0;
                    ack_tgl_r  <= req_seen_r;
                    lk_st_r    <= LK_IDLE;
                end
            endcase
        end
    end
    // Address/data/qualifiers change only at load; branch qualifier is live, one driver
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            la_addr         <= '0;
            la_data         <= '0;
            qualifier_lines <= '0;
        end else begin
            qualifier_lines[Q_BRANCH] <= branch_s;
            if (load) begin
                la_addr <= {8'h00, hold_ext_addr_r, hold_r[PKT_W-1 -: ADDR_W]};
                la_data <= {8'h00, hold_ext_data_r, hold_r[PKT_W-ADDR_W-1 -: DATA_W]};
                qualifier_lines[Q_IRQ_ACK]  <= hold_r[PKT_W-ADDR_W-DATA_W-1];
                qualifier_lines[Q_PROG_SP]  <= hold_r[PKT_W-ADDR_W-DATA_W-2];
                qualifier_lines[Q_RW_READ]  <= hold_r[PKT_W-ADDR_W-DATA_W-3];
                qualifier_lines[Q_IFETCH]   <= hold_r[PKT_W-ADDR_W-DATA_W-4];
                qualifier_lines[Q_PA_VALID] <= hold_r[PKT_W-ADDR_W-DATA_W-5];
                qualifier_lines[Q_DATA_SP]  <= hold_r[PKT_W-ADDR_W-DATA_W-6];
            end
        end
    end
    // Pipeline: event, trace and halt flags shown now belong to the previous sample; run flag follows every edge
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            prev_eval_r       <= 3'b101;
            bp_event_flag     <= 1'b1;
            trace_sample_flag <= 1'b0;
            halt_pending_flag <= 1'b1;
            run_flag          <= 1'b1;
        end else begin
            run_flag <= run_s;
            if (load) begin
                {bp_event_flag, trace_sample_flag, halt_pending_flag} <= prev_eval_r;
                prev_eval_r <= {hold_evt_r, hold_trc_r, hold_zro_r};
            end
        end
    end
    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign s_awready = !aw_got_r && !s_bvalid;
    assign s_wready  = !w_got_r && !s_bvalid;
    assign s_arready = !s_rvalid;
    // Address and data may arrive in either order
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            if (aw_got_r && w_got_r) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= (aw_addr_r == OFF_CTRL) ? RESP_OKAY : RESP_DECERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    // Control register; counts above eight clamp to all-address
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_cnt_r <= EXT_CNT_RST;
            alt_run_r <= 1'b0;
        end else if (aw_got_r && w_got_r && aw_addr_r == OFF_CTRL && w_strb_r[0]) begin
            ext_cnt_r <= (w_data_r[CTRL_CNT_LSB +: CNT_W] > EXT_CNT_MAX) ?
                         EXT_CNT_MAX : w_data_r[CTRL_CNT_LSB +: CNT_W];
            alt_run_r <= w_data_r[CTRL_ALT_BIT];
        end
    end
    // Read path answers one cycle after the address is taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= RESP_OKAY;
            s_rdata  <= 32'h0000_0000;
            unique case (s_araddr)
                OFF_CTRL: begin
                    s_rdata[CTRL_CNT_LSB +: CNT_W] <= ext_cnt_r;
                    s_rdata[CTRL_ALT_BIT]          <= alt_run_r;
                end
                OFF_STAT: begin
                    s_rdata[STAT_RUN_BIT]            <= run_sys_r;
                    s_rdata[STAT_EXEC_BIT]           <= exec_sys_r;
                    s_rdata[STAT_DROP_LSB +: 8]      <= drop_cnt_r;
                end
                OFF_EXT: begin
                    s_rdata[PROBE_W-1:0]              <= hold_ext_addr_r;
                    s_rdata[EXT_DATA_LSB +: PROBE_W] <= hold_ext_data_r;
                end
                default: s_rresp <= RESP_DECERR;
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_evt_polarity: assert property (@(posedge clk_sys) disable iff (rst)
        take && bp_cond |=> !hold_evt_r)
        else $error("event flag not low for satisfied condition");
    a_trc_capture: assert property (@(posedge clk_sys) disable iff (rst)
        take |=> hold_trc_r == $past(trace_capture))
        else $error("trace sample bit does not follow capture");
    a_zro_low: assert property (@(posedge clk_sys) disable iff (rst)
        take && events_done && event_count_zero |=> !hold_zro_r)
        else $error("halt pending not low at count zero");
    a_run_follow: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(cmd_entry) |=> run_sys_r ##0 (run_sys_r || $fell(cmd_entry)))
        else $error("running flag not high in command entry");
    a_ext_coherent: assert property (@(posedge clk_sys) disable iff (rst)
        take |=> hold_ext_addr_r == $past(split_addr) && hold_ext_data_r == $past(split_data))
        else $error("probe values not taken with bus cycle");
    a_pwrup_data: assert property (@(posedge clk_sys) disable iff (rst)
        ext_cnt_r == EXT_CNT_RST |-> split_data == probe_s && split_addr == '0)
        else $error("probes not all data at default count");
    a_fall_stable: assert property (@(posedge clk_link) disable iff (rst)
        $fell(sample_clk) |-> $stable(la_addr) && $stable(la_data) && $stable(qualifier_lines[5:0]))
        else $error("port changed at sample clock fall");
    a_flag_lag: assert property (@(posedge clk_link) disable iff (rst)
        load |=> trace_sample_flag == $past(prev_eval_r[1]) ##1 !sample_clk)
        else $error("flags not one sample behind");
    a_qual_dir: assert property (@(posedge clk_link) disable iff (rst)
        load |=> qualifier_lines[Q_RW_READ] == $past(hold_r[PKT_W-ADDR_W-DATA_W-3]))
        else $error("direction qualifier wrong");
    c_sample: cover property (@(posedge clk_link) disable iff (rst) $fell(sample_clk));
    c_drop: cover property (@(posedge clk_sys) disable iff (rst) bus_cycle_stb && busy);
    c_write: cover property (@(posedge clk_sys) disable iff (rst) s_bvalid && s_bready);
    c_ext: cover property (@(posedge clk_sys) disable iff (rst) take && ext_cnt_r != EXT_CNT_RST);
endmodule : ats_tap
`default_nettype wire

// ==== tb/ats_la_model.sv ====
// Analyzer model: latches the tap port on the sample clock falling edge
`timescale 1ns/1ns
`default_nettype none
module ats_la_model
    import ats_pkg::*;
(
    // Observed port
    input  wire logic              sample_clk,
    input  wire logic [PORT_W-1:0] la_addr,
    input  wire logic [PORT_W-1:0] la_data,
    input  wire logic [QUAL_W-1:0] qualifier_lines,
    input  wire logic [2:0]        flags,
    // Latched sample
    output logic      [PORT_W-1:0] cap_addr,
    output logic      [PORT_W-1:0] cap_data,
    output logic      [QUAL_W-1:0] cap_qual,
    output logic      [2:0]        cap_flags,
    output int                     cap_n
);
    initial cap_n = 0;
    // Bus lines only trusted at the falling edge; flags are latched alongside
    always @(negedge sample_clk) begin
        cap_addr  <= la_addr;
        cap_data  <= la_data;
        cap_qual  <= qualifier_lines;
        cap_flags <= flags;
        cap_n     <= cap_n + 1;
    end
endmodule : ats_la_model
`default_nettype wire

// ==== tb/tb_ats_tap.sv ====
// Testbench for the analyzer tap: port samples, probe split, status and registers
`timescale 1ns/1ns
`default_nettype none
module tb_ats_tap;
    import ats_pkg::*;
    logic        clk_sys = 0, clk_link = 0, rst = 1, bus_cycle_stb = 0, branch_in = 0;
    logic        cmd_entry = 0, target_exec = 0, sample_clk, run_flag;
    logic        bp_event_flag, trace_sample_flag, halt_pending_flag;
    logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [15:0] bus_addr = '0, bus_data = '0, xe;
    logic [7:0]  probe_in = '0, s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata, la_addr, la_data, cap_a, cap_d, rd;
    logic [6:0]  qualifier_lines, cap_q;
    logic [5:0]  q = '0;
    logic [3:0]  ev = '0, s_wstrb = 4'hF;
    logic [2:0]  cap_f, fq[$];
    logic [1:0]  s_bresp, s_rresp, rs;
    int          n_fail = 0, checks_done = 0, cap_n, cnt = 0, nd = 0;

    // Emulation clock; link clock at an unrelated phase
    always #50 clk_sys = ~clk_sys;
    initial begin
        #13;
        forever #80 clk_link = ~clk_link;
    end

    ats_tap i_dut (.clk_sys, .rst, .clk_link, .bus_cycle_stb, .bus_addr, .bus_data,
        .irq_accept_qual(q[0]), .prog_space_strobe_qual(q[1]), .rw_read(q[2]),
        .instr_fetch_qual(q[3]), .prog_addr_valid_qual(q[4]), .data_space_strobe_qual(q[5]),
        .bp_cond(ev[0]), .trace_capture(ev[1]), .events_done(ev[2]),
        .event_count_zero(ev[3]), .cmd_entry, .target_exec, .probe_in, .branch_in,
        .la_addr, .la_data, .qualifier_lines, .sample_clk, .run_flag, .bp_event_flag,
        .trace_sample_flag, .halt_pending_flag, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    ats_la_model i_la (.sample_clk, .la_addr, .la_data, .qualifier_lines,
        .flags({bp_event_flag, trace_sample_flag, halt_pending_flag}),
        .cap_addr(cap_a), .cap_data(cap_d), .cap_qual(cap_q), .cap_flags(cap_f), .cap_n);

    // Compare helpers: analyzer samples and register reads
    task automatic chk_port(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH port t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_port
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH reg t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_reg

    // Bus master write; each channel dropped at the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        fork
            begin
                do @(posedge clk_sys); while (!s_awready);
                s_awvalid <= 1'b0;
            end
            begin
                do @(posedge clk_sys); while (!s_wready);
                s_wvalid <= 1'b0;
            end
        join
        do @(posedge clk_sys); while (!s_bvalid);
        rs = s_bresp;
        s_bready <= 1'b0;
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        @(posedge clk_sys);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do @(posedge clk_sys); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_rvalid);
        {rd, rs} = {s_rdata, s_rresp};
        s_rready <= 1'b0;
    endtask : rdw

    // One random bus cycle; probes flip after the strobe so a late sample shows
    task automatic cyc();
        logic [31:0] r, u;
        logic [7:0]  ea, ed;
        int          c0;
        r = $urandom;
        u = $urandom;
        ea = u[7:0] & 8'((1 << cnt) - 1);
        ed = 8'(u[7:0] >> cnt);
        @(posedge clk_sys);
        probe_in  <= u[7:0];
        branch_in <= u[8];
        repeat (4) @(posedge clk_sys);
        {bus_cycle_stb, bus_addr, bus_data, q, ev} <= {1'b1, r, u[14:9], u[18:15]};
        c0 = cap_n;
        nd++;
        repeat (2) @(posedge clk_sys);  // Second strobe edge finds it busy: dropped
        bus_cycle_stb <= 1'b0;
        probe_in      <= ~u[7:0];
        for (int i = 0; i < 60 && cap_n == c0; i++) @(posedge clk_sys);
        chk_port(cap_a, {8'h00, ea, r[31:16]});
        chk_port(cap_d, {8'h00, ed, r[15:0]});
        chk_port(32'(cap_q), {25'h0, u[8], u[14:9]});
        if (fq.size()) chk_port(32'(cap_f), {29'h0, fq.pop_front()});
        fq.push_back({~u[15], u[16], ~(u[17] & u[18])});
        xe = {ed, ea};
        repeat (10) @(posedge clk_sys);
    endtask : cyc

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(45));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        cyc();
        for (int k = 0; k <= 9; k++) begin
            wr(OFF_CTRL, 32'(k));
            chk_reg(32'(rs), 32'(RESP_OKAY));
            cnt = (k > 8) ? 8 : k;
            cyc();
            rdw(OFF_EXT);
            chk_reg(rd & 32'hFFFF, 32'(xe));
        end
        for (int k = 0; k < 8; k++) begin
            wr(OFF_CTRL, {27'h0, k[2], 4'h0});
            {cmd_entry, target_exec} <= 2'(k);
            repeat (12) @(posedge clk_sys);
            chk_port(32'(run_flag), 32'(k[1]));
            rdw(OFF_STAT);
            chk_reg(rd & 32'h3, {30'h0, k[0] & (~k[1] | k[2]), k[1]});
            chk_reg(32'(rd[15:8]), 32'(nd));
        end
        wr(OFF_STAT, 32'hFF);
        chk_reg(32'(rs), 32'(RESP_DECERR));
        rdw(8'h0C);
        chk_reg({rd[29:0], rs}, 32'(RESP_DECERR));
        close_out();
    end
endmodule : tb_ats_tap
`default_nettype wire
